// File: src/ccr_pkg.sv
// Constants and types for the calibration command responder.
// Assumes one 40 MHz clock and an active-low asynchronous reset.
//
// Contract
// - Info query returns one line of all constants, 'c' at column 0.
// - Light offset at columns 2-13, zero padded decimal, then 'm'.
// - Dark period at columns 15-26, seconds with three decimals, 's'.
// - Light cal temperature columns 28-34, space or minus sign leading.
// - Reference sensor offset at columns 36-47; light cal targets 8.71.
// - Dark cal temperature columns 49-55, signed like light temperature.
// - Info reply ends with CR then LF at columns 56 and 57.
// - Light arm command arms light cal; reply 'z' col 0, 'a' col 2.
// - Light arm reply: 'A' col 1, lock char col 3, CR LF cols 4-5.
// - Lock 'L': armed cal waits for unlock; firmware upgrade blocked.
// - Lock 'U': armed cal runs once the reply has been sent; firmware upgrade allowed.
// - Dark arm command arms dark cal; reply "zBa", lock, CR LF.
// - Disarm clears both arms; reply "zxd", lock char, CR LF.
package ccr_pkg;
   localparam logic [7:0] CCR_CH_CR    = 8'h0D;
   localparam logic [7:0] CCR_CH_LF    = 8'h0A;
   localparam logic [7:0] CCR_CH_COMMA = 8'h2C;
   localparam logic [7:0] CCR_CH_SPACE = 8'h20;
   localparam logic [7:0] CCR_CH_MINUS = 8'h2D;
   localparam logic [7:0] CCR_CH_DOT   = 8'h2E;
   localparam logic [7:0] CCR_CH_ZERO  = 8'h30;
   localparam logic [7:0] CCR_CH_C     = 8'h63;
   localparam logic [7:0] CCR_CH_Z     = 8'h7A;
   localparam logic [7:0] CCR_CH_X     = 8'h78;
   localparam logic [7:0] CCR_CH_A_UP  = 8'h41;
   localparam logic [7:0] CCR_CH_B_UP  = 8'h42;
   localparam logic [7:0] CCR_CH_D_UP  = 8'h44;
   localparam logic [7:0] CCR_CH_A_LO  = 8'h61;
   localparam logic [7:0] CCR_CH_D_LO  = 8'h64;
   localparam logic [7:0] CCR_CH_L_UP  = 8'h4C;
   localparam logic [7:0] CCR_CH_U_UP  = 8'h55;
   localparam logic [7:0] CCR_CH_M     = 8'h6D;
   localparam logic [7:0] CCR_CH_S     = 8'h73;
   localparam logic [7:0] CCR_CH_C_UP  = 8'h43;
   // Column layout of the info and arm replies
   localparam int CCR_INFO_LEN   = 58;
   localparam int CCR_ARM_LEN    = 6;
   localparam int CCR_OFS_LIGHT  = 2;
   localparam int CCR_OFS_DARK   = 15;
   localparam int CCR_OFS_LTEMP  = 28;
   localparam int CCR_OFS_REF    = 36;
   localparam int CCR_OFS_DTEMP  = 49;
   localparam int CCR_OFS_CR     = 56;
   localparam int CCR_VAL_DIGITS = 10;
   localparam int CCR_TMP_DIGITS = 4;
   localparam logic [5:0] CCR_COL_RST = 6'h00;
   typedef enum logic [2:0] {
      CCR_CMD_NONE, CCR_CMD_INFO, CCR_CMD_LARM, CCR_CMD_DARM, CCR_CMD_DIS
   } ccr_cmd_t;
   typedef enum logic [1:0] {CCR_IDLE, CCR_SEND, CCR_WAIT} ccr_state_t;
endpackage : ccr_pkg

// File: src/ccr_field.sv
// One reply field: picks a digit or decoration for a column offset.
// Assumes value digits arrive as BCD, most significant first.
module ccr_field
   import ccr_pkg::*;
#(
   parameter int DIGITS = 10,
   parameter int FRAC   = 2
) (
   input  wire logic [4*DIGITS-1:0] bcd_i,
   input  wire logic                signed_i,
   input  wire logic                neg_i,
   input  wire logic [7:0]          suffix_i,
   input  wire logic [5:0]          pos_i,
   output logic      [7:0]          char_o
);
   // Layout: [sign] int digits '.' frac digits suffix
   localparam int INT_D = DIGITS - FRAC;
   always_comb begin
      int p;
      int d;
      p = int'(pos_i);
      d = 0;
      char_o = CCR_CH_SPACE;
      if (signed_i && p == 0) begin
         char_o = neg_i ? CCR_CH_MINUS : CCR_CH_SPACE;
      end else begin
         if (signed_i) p = p - 1;
         if (p < INT_D) begin
            d = p;
            char_o = CCR_CH_ZERO | {4'h0, bcd_i[4*(DIGITS-1-d) +: 4]};
         end else if (p == INT_D) begin
            char_o = CCR_CH_DOT;
         end else if (p < DIGITS + 1) begin
            d = p - 1;
            char_o = CCR_CH_ZERO | {4'h0, bcd_i[4*(DIGITS-1-d) +: 4]};
         end else begin
            char_o = suffix_i;
         end
      end
   end
endmodule : ccr_field

// File: src/ccr_responder.sv
// Calibration command responder: decodes a command pulse, streams the
// reply bytes with valid/ready, and keeps the light and dark arm flags.
// Assumes commands come pre-parsed from a line decoder on the same clock.
module ccr_responder
   import ccr_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        resetn_i,
   input  wire logic        calibration_info_query_i,
   input  wire logic        light_cal_arm_command_i,
   input  wire logic        dark_cal_arm_command_i,
   input  wire logic        cal_disarm_command_i,
   input  wire logic        unlocked_i,
   input  wire logic        cal_done_light_i,
   input  wire logic        cal_done_dark_i,
   input  wire logic [39:0] light_offset_bcd_i,
   input  wire logic [39:0] dark_period_bcd_i,
   input  wire logic [15:0] light_temp_bcd_i,
   input  wire logic        light_temp_neg_i,
   input  wire logic [39:0] ref_offset_bcd_i,
   input  wire logic [15:0] dark_temp_bcd_i,
   input  wire logic        dark_temp_neg_i,
   input  wire logic        tx_ready_i,
   output logic             tx_valid_o,
   output logic      [7:0]  tx_data_o,
   output logic             busy_o,
   output logic             light_armed_o,
   output logic             dark_armed_o,
   output logic             light_cal_go_o,
   output logic             dark_cal_go_o,
   output logic             fw_upgrade_en_o
);
   ccr_state_t  state_ff,  nxt_state;
   ccr_cmd_t    cmd_ff,    nxt_cmd;
   logic [5:0]  col_ff,    nxt_col;
   logic        valid_ff,  nxt_valid;
   logic [7:0]  data_ff,   nxt_data;
   logic        larm_ff,   nxt_larm;
   logic        darm_ff,   nxt_darm;
   logic        lgo_ff,    nxt_lgo;
   logic        dgo_ff,    nxt_dgo;
   logic        fw_ff,     nxt_fw;
   logic        lock_ff,   nxt_lock;
   logic        busy_ff,   nxt_busy;
   logic [7:0]  c_light, c_dark, c_ltmp, c_ref, c_dtmp;
   logic [7:0]  ch;
   logic [5:0]  last_col;

   ////////////////////////////////////////////////////////////////////////
   // Field formatters, fed with the column relative to each field
   ccr_field #(.DIGITS(CCR_VAL_DIGITS), .FRAC(2)) u_light (
      .bcd_i(light_offset_bcd_i), .signed_i(1'b0), .neg_i(1'b0),
      .suffix_i(CCR_CH_M), .pos_i(col_ff - 6'(CCR_OFS_LIGHT)),
      .char_o(c_light));
   ccr_field #(.DIGITS(CCR_VAL_DIGITS), .FRAC(3)) u_dark (
      .bcd_i(dark_period_bcd_i), .signed_i(1'b0), .neg_i(1'b0),
      .suffix_i(CCR_CH_S), .pos_i(col_ff - 6'(CCR_OFS_DARK)),
      .char_o(c_dark));
   ccr_field #(.DIGITS(CCR_TMP_DIGITS), .FRAC(1)) u_ltmp (
      .bcd_i(light_temp_bcd_i), .signed_i(1'b1),
      .neg_i(light_temp_neg_i), .suffix_i(CCR_CH_C_UP),
      .pos_i(col_ff - 6'(CCR_OFS_LTEMP)), .char_o(c_ltmp));
   ccr_field #(.DIGITS(CCR_VAL_DIGITS), .FRAC(2)) u_ref (
      .bcd_i(ref_offset_bcd_i), .signed_i(1'b0), .neg_i(1'b0),
      .suffix_i(CCR_CH_M), .pos_i(col_ff - 6'(CCR_OFS_REF)),
      .char_o(c_ref));
   ccr_field #(.DIGITS(CCR_TMP_DIGITS), .FRAC(1)) u_dtmp (
      .bcd_i(dark_temp_bcd_i), .signed_i(1'b1),
      .neg_i(dark_temp_neg_i), .suffix_i(CCR_CH_C_UP),
      .pos_i(col_ff - 6'(CCR_OFS_DTEMP)), .char_o(c_dtmp));

   ////////////////////////////////////////////////////////////////////////
   // Character of the current column
   always_comb begin
      ch = CCR_CH_SPACE;
      if (cmd_ff == CCR_CMD_INFO) begin
         if (col_ff == 6'h00) begin
            ch = CCR_CH_C;
         end else if (col_ff == 6'h01 || col_ff == 6'h0E ||
                      col_ff == 6'h1B || col_ff == 6'h23 ||
                      col_ff == 6'h30) begin
            ch = CCR_CH_COMMA;
         end else if (col_ff < 6'(CCR_OFS_DARK)) begin
            ch = c_light;
         end else if (col_ff < 6'(CCR_OFS_LTEMP)) begin
            ch = c_dark;
         end else if (col_ff < 6'(CCR_OFS_REF)) begin
            ch = c_ltmp;
         end else if (col_ff < 6'(CCR_OFS_DTEMP)) begin
            ch = c_ref;
         end else if (col_ff < 6'(CCR_OFS_CR)) begin
            ch = c_dtmp;
         end else if (col_ff == 6'(CCR_OFS_CR)) begin
            ch = CCR_CH_CR;
         end else begin
            ch = CCR_CH_LF;
         end
      end else begin
         case (col_ff)
            6'h00: ch = CCR_CH_Z;
            6'h01: begin
               case (cmd_ff)
                  CCR_CMD_LARM: ch = CCR_CH_A_UP;
                  CCR_CMD_DARM: ch = CCR_CH_B_UP;
                  default:      ch = CCR_CH_X;
               endcase
            end
            6'h02: ch = (cmd_ff == CCR_CMD_DIS) ? CCR_CH_D_LO
                                                : CCR_CH_A_LO;
            6'h03: ch = lock_ff ? CCR_CH_L_UP : CCR_CH_U_UP;
            6'h04: ch = CCR_CH_CR;
            default: ch = CCR_CH_LF;
         endcase
      end
   end

   assign last_col = (cmd_ff == CCR_CMD_INFO) ? 6'(CCR_INFO_LEN - 1)
                                              : 6'(CCR_ARM_LEN - 1);

   ////////////////////////////////////////////////////////////////////////
   // Reply sequencer and calibration arm state
   always_comb begin
      nxt_state = state_ff;
      nxt_cmd   = cmd_ff;
      nxt_col   = col_ff;
      nxt_valid = valid_ff;
      nxt_data  = data_ff;
      nxt_larm  = larm_ff;
      nxt_darm  = darm_ff;
      nxt_lock  = lock_ff;
      nxt_lgo   = 1'b0;
      nxt_dgo   = 1'b0;
      nxt_fw    = unlocked_i;
      case (state_ff)
         CCR_IDLE: begin
            nxt_col  = CCR_COL_RST;
            nxt_lock = ~unlocked_i;
            if (calibration_info_query_i) begin
               nxt_cmd   = CCR_CMD_INFO;
               nxt_state = CCR_SEND;
            end else if (light_cal_arm_command_i) begin
               nxt_cmd   = CCR_CMD_LARM;
               nxt_larm  = 1'b1;
               nxt_state = CCR_SEND;
            end else if (dark_cal_arm_command_i) begin
               nxt_cmd   = CCR_CMD_DARM;
               nxt_darm  = 1'b1;
               nxt_state = CCR_SEND;
            end else if (cal_disarm_command_i) begin
               nxt_cmd   = CCR_CMD_DIS;
               nxt_larm  = 1'b0;
               nxt_darm  = 1'b0;
               nxt_state = CCR_SEND;
            end
         end
         CCR_SEND: begin
            nxt_valid = 1'b1;
            nxt_data  = ch;
            nxt_state = CCR_WAIT;
         end
         default: begin
            if (tx_ready_i) begin
               nxt_valid = 1'b0;
               if (col_ff == last_col) begin
                  nxt_state = CCR_IDLE;
               end else begin
                  nxt_col   = col_ff + 6'h01;
                  nxt_state = CCR_SEND;
               end
            end
         end
      endcase
      // Registered so that the port comes straight from a flop
      nxt_busy  = (nxt_state != CCR_IDLE);
      // Armed calibration fires only once the device is unlocked
      if (larm_ff && unlocked_i && state_ff == CCR_IDLE) begin
         nxt_lgo  = 1'b1;
      end
      if (darm_ff && unlocked_i && state_ff == CCR_IDLE) begin
         nxt_dgo  = 1'b1;
      end
      // Completion clears the arm unless a new arm arrives this cycle
      if (cal_done_light_i && !(state_ff == CCR_IDLE &&
          light_cal_arm_command_i && !calibration_info_query_i)) begin
         nxt_larm = 1'b0;
      end
      if (cal_done_dark_i && !(state_ff == CCR_IDLE &&
          dark_cal_arm_command_i && !calibration_info_query_i &&
          !light_cal_arm_command_i)) begin
         nxt_darm = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff <= CCR_IDLE;
         cmd_ff   <= CCR_CMD_NONE;
         col_ff   <= CCR_COL_RST;
         valid_ff <= 1'b0;
         data_ff  <= 8'h00;
         larm_ff  <= 1'b0;
         darm_ff  <= 1'b0;
         lgo_ff   <= 1'b0;
         dgo_ff   <= 1'b0;
         fw_ff    <= 1'b0;
         lock_ff  <= 1'b1;
         busy_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cmd_ff   <= nxt_cmd;
         col_ff   <= nxt_col;
         valid_ff <= nxt_valid;
         data_ff  <= nxt_data;
         larm_ff  <= nxt_larm;
         darm_ff  <= nxt_darm;
         lgo_ff   <= nxt_lgo;
         dgo_ff   <= nxt_dgo;
         fw_ff    <= nxt_fw;
         lock_ff  <= nxt_lock;
         busy_ff  <= nxt_busy;
      end
   end

   assign tx_valid_o      = valid_ff;
   assign tx_data_o       = data_ff;
   assign busy_o          = busy_ff;
   assign light_armed_o   = larm_ff;
   assign dark_armed_o    = darm_ff;
   assign light_cal_go_o  = lgo_ff;
   assign dark_cal_go_o   = dgo_ff;
   assign fw_upgrade_en_o = fw_ff;
endmodule : ccr_responder

// File: tb/ccr_responder_monitor.sv
// Port checker for the calibration command responder.
// Assumes it is bound into ccr_responder; one clock, async active-low reset.
module ccr_responder_monitor
   import ccr_pkg::*;
(
   input wire logic       clk_sys_i,
   input wire logic       resetn_i,
   input wire logic       calibration_info_query_i,
   input wire logic       light_cal_arm_command_i,
   input wire logic       dark_cal_arm_command_i,
   input wire logic       cal_disarm_command_i,
   input wire logic       unlocked_i,
   input wire logic       tx_ready_i,
   input wire logic       tx_valid_o,
   input wire logic [7:0] tx_data_o,
   input wire logic       busy_o,
   input wire logic       light_armed_o,
   input wire logic       dark_armed_o,
   input wire logic       light_cal_go_o,
   input wire logic       dark_cal_go_o,
   input wire logic       fw_upgrade_en_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic arm;
   logic cmd;
   assign arm = light_cal_arm_command_i | dark_cal_arm_command_i
              | cal_disarm_command_i;
   assign cmd = calibration_info_query_i | arm;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   ////////////////////////////////////////////////////////////////////////
   a_reply_start: assert property (
      cmd && !busy_o |=> busy_o && !tx_valid_o ##1 tx_valid_o)
      else $error("reply did not start two cycles after a command");
   a_info_lead: assert property (
      calibration_info_query_i && !busy_o |-> ##2 tx_data_o == CCR_CH_C)
      else $error("info reply does not open with c");
   a_arm_lead: assert property (
      arm && !calibration_info_query_i && !busy_o
      |-> ##2 tx_data_o == CCR_CH_Z)
      else $error("arm reply does not open with z");
   a_byte_hold: assert property (
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("reply byte changed before acceptance");
   a_light_arm: assert property (
      light_cal_arm_command_i && !calibration_info_query_i && !busy_o
      |=> light_armed_o)
      else $error("light arm command did not arm");
   a_disarm_clear: assert property (
      cal_disarm_command_i && !calibration_info_query_i && !busy_o
      && !light_cal_arm_command_i && !dark_cal_arm_command_i
      |=> !light_armed_o && !dark_armed_o)
      else $error("disarm left a calibration armed");
   a_go_cause: assert property (
      light_cal_go_o |-> $past(light_armed_o) && $past(unlocked_i))
      else $error("light calibration ran while locked or unarmed");
   a_fw_follow: assert property (
      $past(resetn_i) |-> fw_upgrade_en_o == $past(unlocked_i))
      else $error("firmware upgrade enable does not follow lock state");
   a_locked_wait: assert property (
      !unlocked_i |=> !light_cal_go_o && !dark_cal_go_o)
      else $error("calibration ran while locked");
   a_dark_arm: assert property (
      dark_cal_arm_command_i && !calibration_info_query_i
      && !light_cal_arm_command_i && !busy_o |=> dark_armed_o)
      else $error("dark arm command did not arm");
   a_dark_go_cause: assert property (
      dark_cal_go_o |-> $past(dark_armed_o) && $past(unlocked_i))
      else $error("dark calibration ran while locked or unarmed");
endmodule : ccr_responder_monitor

bind ccr_responder ccr_responder_monitor i_ccr_responder_monitor (
   .clk_sys_i                (clk_sys_i),
   .resetn_i                 (resetn_i),
   .calibration_info_query_i (calibration_info_query_i),
   .light_cal_arm_command_i  (light_cal_arm_command_i),
   .dark_cal_arm_command_i   (dark_cal_arm_command_i),
   .cal_disarm_command_i     (cal_disarm_command_i),
   .unlocked_i               (unlocked_i),
   .tx_ready_i               (tx_ready_i),
   .tx_valid_o               (tx_valid_o),
   .tx_data_o                (tx_data_o),
   .busy_o                   (busy_o),
   .light_armed_o            (light_armed_o),
   .dark_armed_o             (dark_armed_o),
   .light_cal_go_o           (light_cal_go_o),
   .dark_cal_go_o            (dark_cal_go_o),
   .fw_upgrade_en_o          (fw_upgrade_en_o)
);

// File: tb/ccr_host_model.sv
// Host software end of the reply stream: takes bytes, may stall at random.
// Assumes valid/ready on the responder's clock; bytes kept in rx_q.
module ccr_host_model (
   input  wire logic       clk_sys_i,
   input  wire logic       resetn_i,
   input  wire logic       slow_i,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   output logic            tx_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rx_q[$];
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_ready_o <= 1'b0;
      end else begin
         if (tx_valid_i && tx_ready_o) begin
            rx_q.push_back(tx_data_i);
         end
         tx_ready_o <= slow_i ? 1'($urandom_range(1)) : 1'b1;
      end
   end
endmodule : ccr_host_model

// File: tb/tb.sv
// Self-checking bench for the calibration command responder.
// Assumes the host model consumes replies; arms tracked in el and ed.
module tb
   import ccr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [3:0]  cmd = 4'h0;
   logic [1:0]  done = 2'h0;
   logic        unl = 1'b0, slow = 1'b0, lneg = 1'b0, dneg = 1'b0;
   logic [39:0] lofs = 40'h0, dper = 40'h0, rofs = 40'h0;
   logic [15:0] ltmp = 16'h0, dtmp = 16'h0;
   logic        ready, valid, busy, larm, darm, lgo, dgo, fw, el, ed;
   logic [7:0]  data;
   logic [7:0]  exp_q[$];
   int          mismatches = 0, total_checks = 0, cycles = 0;
   ccr_responder i_ccr_responder (.clk_sys_i(clk), .resetn_i(resetn),
      .calibration_info_query_i(cmd[0]), .light_cal_arm_command_i(cmd[1]),
      .dark_cal_arm_command_i(cmd[2]), .cal_disarm_command_i(cmd[3]),
      .unlocked_i(unl), .cal_done_light_i(done[0]), .cal_done_dark_i(done[1]),
      .light_offset_bcd_i(lofs), .dark_period_bcd_i(dper),
      .light_temp_bcd_i(ltmp), .light_temp_neg_i(lneg),
      .ref_offset_bcd_i(rofs), .dark_temp_bcd_i(dtmp), .dark_temp_neg_i(dneg),
      .tx_ready_i(ready), .tx_valid_o(valid), .tx_data_o(data), .busy_o(busy),
      .light_armed_o(larm), .dark_armed_o(darm), .light_cal_go_o(lgo),
      .dark_cal_go_o(dgo), .fw_upgrade_en_o(fw));
   ccr_host_model i_ccr_host_model (.clk_sys_i(clk), .resetn_i(resetn),
      .slow_i(slow), .tx_valid_i(valid), .tx_data_i(data), .tx_ready_o(ready));
   always #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (mismatches == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         test_done();
      end
   end
   task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_byte
   task automatic chk_bit(string nm, logic e, logic g);
      chk_byte(nm, {7'h0, e}, {7'h0, g});
   endtask : chk_bit
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [39:0] rnd_bcd();
      logic [39:0] v;
      for (int i = 0; i < 10; i++) v[4*i+:4] = 4'($urandom_range(9));
      return v;
   endfunction : rnd_bcd
   // Digits most significant first, a point before the fraction, then suffix and comma
   function automatic void put_num(logic [39:0] b, int n, int fr,
                                   logic [7:0] lead, logic [7:0] suf);
      if (lead != 8'h00) exp_q.push_back(lead);
      for (int i = n - 1; i >= 0; i--) begin
         if (i == fr - 1) exp_q.push_back(CCR_CH_DOT);
         exp_q.push_back(CCR_CH_ZERO + {4'h0, b[4*i+:4]});
      end
      exp_q.push_back(suf);
      exp_q.push_back(CCR_CH_COMMA);
   endfunction : put_num
   task automatic run_cmd(int k, int extra);
      i_ccr_host_model.rx_q.delete();
      @(posedge clk);
      cmd[k] <= 1'b1;
      exp_q = '{CCR_CH_Z, CCR_CH_X, CCR_CH_D_LO};
      case (k)
         0: begin
            exp_q = '{CCR_CH_C, CCR_CH_COMMA};
            put_num(lofs, 10, 2, 8'h00, CCR_CH_M);
            put_num(dper, 10, 3, 8'h00, CCR_CH_S);
            put_num(40'(ltmp), 4, 1, lneg ? CCR_CH_MINUS : CCR_CH_SPACE,
                    CCR_CH_C_UP);
            put_num(rofs, 10, 2, 8'h00, CCR_CH_M);
            put_num(40'(dtmp), 4, 1, dneg ? CCR_CH_MINUS : CCR_CH_SPACE,
                    CCR_CH_C_UP);
            exp_q[56] = CCR_CH_CR;
         end
         1: begin
            exp_q[1] = CCR_CH_A_UP;
            exp_q[2] = CCR_CH_A_LO;
            el = 1'b1;
         end
         2: begin
            exp_q[1] = CCR_CH_B_UP;
            exp_q[2] = CCR_CH_A_LO;
            ed = 1'b1;
         end
         default: begin
            el = 1'b0;
            ed = 1'b0;
         end
      endcase
      if (k != 0) exp_q = {exp_q, unl ? CCR_CH_U_UP : CCR_CH_L_UP, CCR_CH_CR};
      exp_q.push_back(CCR_CH_LF);
      @(posedge clk);
      cmd <= 4'h0;
      // A second command while busy must be ignored entirely
      if (extra >= 0) begin
         repeat (3) @(posedge clk);
         cmd[extra] <= 1'b1;
         @(posedge clk);
         cmd <= 4'h0;
      end
      #1;
      for (int i = 0; i < 600 && busy !== 1'b0; i++) @(posedge clk);
      #1;
      chk_byte("reply length", 8'(exp_q.size()),
               8'(i_ccr_host_model.rx_q.size()));
      foreach (exp_q[j]) chk_byte("reply byte", exp_q[j],
                                  i_ccr_host_model.rx_q[j]);
      chk_bit("light armed", el, larm);
      chk_bit("dark armed", ed, darm);
   endtask : run_cmd
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h6C06));
      {el, ed} = 2'b00;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      for (int n = 0; n < 4; n++) begin
         @(posedge clk);
         lofs <= rnd_bcd();
         dper <= rnd_bcd() & 40'h00000FFFFF | 40'h0000100000;
         rofs <= n == 0 ? 40'h0000000871 : rnd_bcd();
         ltmp <= 16'(rnd_bcd());
         dtmp <= 16'(rnd_bcd());
         {lneg, dneg, slow} <= 3'($urandom);
         run_cmd(0, -1);
      end
      run_cmd(1, 3);
      repeat (3) @(posedge clk);
      #1;
      chk_bit("light go", 1'b0, lgo);
      chk_bit("fw enable", 1'b0, fw);
      @(posedge clk);
      unl <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk_bit("light go", 1'b1, lgo);
      chk_bit("fw enable", 1'b1, fw);
      @(posedge clk);
      done <= 2'b01;
      el = 1'b0;
      @(posedge clk);
      done <= 2'b00;
      run_cmd(2, -1);
      repeat (3) @(posedge clk);
      #1;
      chk_bit("dark go", 1'b1, dgo);
      run_cmd(3, -1);
      // Arm and completion on the same edge: the arm must win
      fork
         run_cmd(2, -1);
         begin
            @(posedge clk);
            done <= 2'b10;
            @(posedge clk);
            done <= 2'b00;
         end
      join
      @(posedge clk);
      done <= 2'b10;
      ed = 1'b0;
      @(posedge clk);
      done <= 2'b00;
      @(posedge clk);
      #1;
      chk_bit("dark armed", ed, darm);
      chk_bit("dark go", 1'b0, dgo);
      for (int n = 0; n < 12; n++) begin
         @(posedge clk);
         {unl, slow} <= 2'($urandom);
         run_cmd($urandom_range(3), -1);
      end
      // Reset in mid-run clears the arms and every output
      @(posedge clk);
      resetn <= 1'b0;
      {el, ed} = 2'b00;
      repeat (2) @(posedge clk);
      #1;
      chk_byte("reset outputs", 8'h00,
               {valid, busy, larm, darm, lgo, dgo, fw, 1'b0});
      chk_byte("reset data", 8'h00, data);
      @(posedge clk);
      resetn <= 1'b1;
      run_cmd(3, -1);
      test_done();
   end
endmodule : tb
